/* File: design/exc_vector_pkg.sv */
package exc_vector_pkg;

    // ****************************************
    // Register offsets on the plain register port
    // ****************************************
    localparam logic [7:0] OFS_ORD_SAVE_PC   = 8'h00;
    localparam logic [7:0] OFS_ORD_SAVE_ST   = 8'h04;
    localparam logic [7:0] OFS_FAT_SAVE_PC   = 8'h08;
    localparam logic [7:0] OFS_FAT_SAVE_ST   = 8'h0C;
    localparam logic [7:0] OFS_CAUSE         = 8'h10;
    localparam logic [7:0] OFS_PSW           = 8'h14;
    localparam logic [7:0] OFS_HW_CONFIG     = 8'h18;
    localparam logic [7:0] OFS_EVT_STATUS    = 8'h1C;
    localparam logic [7:0] OFS_EVT_MASK      = 8'h20;

    // ****************************************
    // Field positions and reset values
    // ****************************************
    localparam int         PSW_ID_BIT        = 5;
    localparam int         PSW_PEND_BIT      = 6;
    localparam int         PSW_NMI_BIT       = 7;
    localparam int         HWC_AREA_BIT      = 0;
    localparam logic [31:0] PSW_RESET        = 32'h0000_0020;
    localparam logic [31:0] CAUSE_RESET      = 32'h0000_FFF0;
    localparam logic [31:0] HWC_RESET        = 32'h0000_0000;

    // Event status bits
    localparam int         EVB_RESET         = 0;
    localparam int         EVB_FATAL         = 1;
    localparam int         EVB_NMI           = 2;
    localparam int         EVB_INT           = 3;
    localparam int         EVB_TRAP          = 4;
    localparam int         EVB_ILLEGAL       = 5;
    localparam int         EVB_DIVZ          = 6;
    localparam int         EVB_W             = 7;

    // ****************************************
    // Cause codes and handler addresses
    // ****************************************
    localparam logic [15:0] CODE_RESET       = 16'hFFF0;
    localparam logic [15:0] CODE_NMI         = 16'hFFD0;
    localparam logic [15:0] CODE_ILLEGAL     = 16'hFF90;
    localparam logic [15:0] CODE_DIVZ        = 16'hFF80;
    localparam logic [11:0] CODE_TRAP0_HI    = 12'hFFA;
    localparam logic [11:0] CODE_TRAP1_HI    = 12'hFFB;
    localparam logic [7:0]  CODE_INT_HI      = 8'hFE;
    localparam logic [31:0] HND_RESET        = 32'hFFFF_FFF0;
    localparam logic [31:0] HND_FATAL        = 32'hFFFF_FFE0;
    localparam logic [31:0] HND_NMI          = 32'hFFFF_FFD0;
    localparam logic [31:0] HND_TRAP1        = 32'hFFFF_FFB0;
    localparam logic [31:0] HND_TRAP0        = 32'hFFFF_FFA0;
    localparam logic [31:0] HND_ILLEGAL      = 32'hFFFF_FF90;
    localparam logic [31:0] HND_DIVZ         = 32'hFFFF_FF80;
    localparam logic [23:0] HND_INT_LOW_HI   = 24'hFFFFFE;
    localparam logic [23:0] HND_INT_HIGH_HI  = 24'hFE0000;

    typedef enum logic [2:0] {
        EV_NONE, EV_RESET, EV_FATAL, EV_NMI, EV_INT, EV_TRAP, EV_ILLEGAL, EV_DIVZ
    } event_t;

endpackage

/* File: design/exception_trap_vectoring.sv */
`timescale 1ns/1ps
// Notes on behaviour
// (RL1) Interrupts outrank ordinary exceptions
// (RL2) Fatal exception outranks every interrupt
// (RL3) Maskable and nonmaskable interrupts; synchronous exceptions
// (RL4) Each cause vectors to a fixed handler
// (RL5) Cause code recorded in cause register
// (RL6) Trap saves PC/status, pair chosen by pending flag
// (RL7) Trap code into fatal or ordinary half
// (RL8) Trap vectors 0-31, codes FFAn/FFBn, next PC
// (RL9) Level n interrupt: FEn0 code, two handler areas
// (RL10) Fixed codes and handlers for other causes
// (RL11) Reset vectors with code FFF0
module exception_trap_vectoring
    import exc_vector_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        nrst_i,
    input  wire logic        fatal_req_i,
    input  wire logic [15:0] fatal_code_i,
    input  wire logic        nmi_req_i,
    input  wire logic        int_req_i,
    input  wire logic [3:0]  int_level_i,
    input  wire logic        trap_req_i,
    input  wire logic [4:0]  trap_vector_i,
    input  wire logic        illegal_op_i,
    input  wire logic        div_zero_i,
    input  wire logic [31:0] cur_pc_i,
    input  wire logic [31:0] next_pc_i,
    input  wire logic [7:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        we_i,
    input  wire logic        re_i,
    output logic [31:0]      rdata_o,
    output logic             redirect_o,
    output logic [31:0]      handler_addr_o,
    output logic [15:0]      cause_code_o,
    output logic             irq_o
);

    // ****************************************
    // State
    // ****************************************
    logic [31:0]    ord_save_pc_ff;
    logic [31:0]    ord_save_st_ff;
    logic [31:0]    fat_save_pc_ff;
    logic [31:0]    fat_save_st_ff;
    logic [31:0]    cause_ff;
    logic [31:0]    psw_ff;
    logic [31:0]    hwc_ff;
    logic [EVB_W-1:0] evt_status_ff;
    logic [EVB_W-1:0] evt_mask_ff;
    logic           reset_pend_ff;
    logic [31:0]    rdata_ff;
    logic           redirect_ff;
    logic [31:0]    handler_ff;
    logic [15:0]    code_ff;

    event_t         sel;
    logic [15:0]    nxt_code;
    logic [31:0]    nxt_handler;
    logic [31:0]    ret_pc;
    logic           use_fatal;
    logic           do_save;
    logic [EVB_W-1:0] evt_set;
    logic           flag_pend;
    logic           flag_nmi_busy;
    logic           flag_id;

    assign flag_pend = psw_ff[PSW_PEND_BIT];
    assign flag_nmi_busy = psw_ff[PSW_NMI_BIT];
    assign flag_id = psw_ff[PSW_ID_BIT];

    // ****************************************
    // Arbitration
    // ****************************************
    // Rank: reset, fatal, nmi, maskable, then synchronous exceptions
    always_comb begin
        if (reset_pend_ff) begin
            sel = EV_RESET;                                 // see RL11
        end else if (fatal_req_i) begin
            sel = EV_FATAL;                                 // see RL2
        end else if (nmi_req_i && !flag_nmi_busy) begin
            sel = EV_NMI;                                   // see RL3
        end else if (int_req_i && !flag_id && !flag_nmi_busy) begin
            sel = EV_INT;                                   // see RL1
        end else if (trap_req_i) begin
            sel = EV_TRAP;                                  // see RL3
        end else if (illegal_op_i) begin
            sel = EV_ILLEGAL;
        end else if (div_zero_i) begin
            sel = EV_DIVZ;
        end else begin
            sel = EV_NONE;
        end
    end

    // Code, handler, return PC and save pair per cause
    always_comb begin
        nxt_code    = 16'h0000;
        nxt_handler = 32'h0000_0000;
        ret_pc      = next_pc_i;
        use_fatal   = flag_pend;                            // see RL6
        do_save     = 1'b1;
        evt_set     = '0;
        case (sel)
            EV_RESET: begin
                nxt_code    = CODE_RESET;                   // see RL11
                nxt_handler = HND_RESET;
                do_save     = 1'b0;
                evt_set[EVB_RESET] = 1'b1;
            end
            EV_FATAL: begin
                nxt_code    = fatal_code_i;
                nxt_handler = HND_FATAL;                    // see RL10
                ret_pc      = cur_pc_i;
                use_fatal   = 1'b1;
                evt_set[EVB_FATAL] = 1'b1;
            end
            EV_NMI: begin
                nxt_code    = CODE_NMI;                     // see RL10
                nxt_handler = HND_NMI;
                use_fatal   = 1'b1;
                evt_set[EVB_NMI] = 1'b1;
            end
            EV_INT: begin
                nxt_code    = {CODE_INT_HI, int_level_i, 4'h0};        // see RL9
                if (hwc_ff[HWC_AREA_BIT]) begin
                    nxt_handler = {HND_INT_HIGH_HI, int_level_i, 4'h0};
                end else begin
                    nxt_handler = {HND_INT_LOW_HI, int_level_i, 4'h0};
                end
                evt_set[EVB_INT] = 1'b1;
            end
            EV_TRAP: begin
                if (trap_vector_i[4]) begin
                    nxt_code    = {CODE_TRAP1_HI, trap_vector_i[3:0]}; // see RL8
                    nxt_handler = HND_TRAP1;
                end else begin
                    nxt_code    = {CODE_TRAP0_HI, trap_vector_i[3:0]};
                    nxt_handler = HND_TRAP0;
                end
                evt_set[EVB_TRAP] = 1'b1;
            end
            EV_ILLEGAL: begin
                nxt_code    = CODE_ILLEGAL;                 // see RL10
                nxt_handler = HND_ILLEGAL;
                ret_pc      = cur_pc_i;
                evt_set[EVB_ILLEGAL] = 1'b1;
            end
            EV_DIVZ: begin
                nxt_code    = CODE_DIVZ;
                nxt_handler = HND_DIVZ;
                ret_pc      = cur_pc_i;
                evt_set[EVB_DIVZ] = 1'b1;
            end
            default: begin
                do_save     = 1'b0;
            end
        endcase
    end

    // ****************************************
    // Entry outputs
    // ****************************************
    // Reset is serviced once, right after release
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            reset_pend_ff <= 1'b1;
        end else begin
            reset_pend_ff <= 1'b0;
        end
    end

    // Redirect pulse with handler and cause
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            redirect_ff <= 1'b0;
            handler_ff  <= 32'h0000_0000;
            code_ff     <= 16'h0000;
        end else begin
            redirect_ff <= (sel != EV_NONE);                // see RL4
            if (sel != EV_NONE) begin
                handler_ff <= nxt_handler;
                code_ff    <= nxt_code;
            end
        end
    end

    assign redirect_o     = redirect_ff;
    assign handler_addr_o = handler_ff;
    assign cause_code_o   = code_ff;

    // ****************************************
    // Save pairs, cause and status word
    // ****************************************
    // Save pairs: hardware entry beats software write
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ord_save_pc_ff <= 32'h0000_0000;
            ord_save_st_ff <= 32'h0000_0000;
            fat_save_pc_ff <= 32'h0000_0000;
            fat_save_st_ff <= 32'h0000_0000;
        end else if (do_save && use_fatal) begin
            fat_save_pc_ff <= ret_pc;                       // see RL6
            fat_save_st_ff <= psw_ff;
        end else if (do_save) begin
            ord_save_pc_ff <= ret_pc;                       // see RL6
            ord_save_st_ff <= psw_ff;
        end else if (we_i) begin
            case (addr_i)
                OFS_ORD_SAVE_PC: ord_save_pc_ff <= wdata_i;
                OFS_ORD_SAVE_ST: ord_save_st_ff <= wdata_i;
                OFS_FAT_SAVE_PC: fat_save_pc_ff <= wdata_i;
                OFS_FAT_SAVE_ST: fat_save_st_ff <= wdata_i;
                default: begin
                end
            endcase
        end
    end

    // Cause register halves, read-only to software
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cause_ff <= CAUSE_RESET;                        // see RL11
        end else if (sel == EV_RESET) begin
            cause_ff[15:0] <= nxt_code;
        end else if (do_save && use_fatal) begin
            cause_ff[31:16] <= nxt_code;                    // see RL7
        end else if (do_save) begin
            cause_ff[15:0] <= nxt_code;                     // see RL5
        end
    end

    // Status word flags set on entry
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            psw_ff <= PSW_RESET;
        end else if (do_save) begin
            psw_ff[PSW_ID_BIT] <= 1'b1;                     // see RL6
            if (use_fatal) begin
                psw_ff[PSW_NMI_BIT] <= 1'b1;
            end else begin
                psw_ff[PSW_PEND_BIT] <= 1'b1;
            end
        end else if (we_i && addr_i == OFS_PSW) begin
            psw_ff <= wdata_i;
        end
    end

    // ****************************************
    // Config, event status, mask, read port
    // ****************************************
    // Handler area select
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            hwc_ff <= HWC_RESET;
        end else if (we_i && addr_i == OFS_HW_CONFIG) begin
            hwc_ff <= {31'h0000_0000, wdata_i[HWC_AREA_BIT]};
        end
    end

    // Sticky events, write one clears, set wins
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            evt_status_ff <= '0;
        end else if (we_i && addr_i == OFS_EVT_STATUS) begin
            evt_status_ff <= (evt_status_ff & ~wdata_i[EVB_W-1:0]) | evt_set;
        end else begin
            evt_status_ff <= evt_status_ff | evt_set;
        end
    end

    // Interrupt mask
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            evt_mask_ff <= '0;
        end else if (we_i && addr_i == OFS_EVT_MASK) begin
            evt_mask_ff <= wdata_i[EVB_W-1:0];
        end
    end

    assign irq_o = |(evt_status_ff & evt_mask_ff);

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_ff <= 32'h0000_0000;
        end else if (re_i) begin
            case (addr_i)
                OFS_ORD_SAVE_PC: rdata_ff <= ord_save_pc_ff;
                OFS_ORD_SAVE_ST: rdata_ff <= ord_save_st_ff;
                OFS_FAT_SAVE_PC: rdata_ff <= fat_save_pc_ff;
                OFS_FAT_SAVE_ST: rdata_ff <= fat_save_st_ff;
                OFS_CAUSE:       rdata_ff <= cause_ff;
                OFS_PSW:         rdata_ff <= psw_ff;
                OFS_HW_CONFIG:   rdata_ff <= hwc_ff;
                OFS_EVT_STATUS:  rdata_ff <= {{(32-EVB_W){1'b0}}, evt_status_ff};
                OFS_EVT_MASK:    rdata_ff <= {{(32-EVB_W){1'b0}}, evt_mask_ff};
                default:         rdata_ff <= 32'h0000_0000;
            endcase
        end else begin
            rdata_ff <= 32'h0000_0000;
        end
    end

    assign rdata_o = rdata_ff;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    a_reset_vector_taken: assert property (                        // see RL11
        reset_pend_ff |=> redirect_o && handler_addr_o == HND_RESET
            && cause_code_o == CODE_RESET)
        else $error("reset entry not vectored");

    a_fatal_beats_int: assert property (                           // see RL2
        fatal_req_i && !reset_pend_ff && (nmi_req_i || int_req_i)
            |=> redirect_o && handler_addr_o == HND_FATAL)
        else $error("fatal exception lost to interrupt");

    a_int_beats_exc: assert property (                             // see RL1
        int_req_i && !flag_id && !flag_nmi_busy && !fatal_req_i && !nmi_req_i
            && !reset_pend_ff && (trap_req_i || illegal_op_i)
            |=> cause_code_o[15:8] == CODE_INT_HI)
        else $error("exception taken ahead of interrupt");
    a_masked_int_held: assert property (                           // see RL3
        int_req_i && flag_id && !reset_pend_ff && !fatal_req_i && !nmi_req_i
            && !trap_req_i && !illegal_op_i && !div_zero_i |=> !redirect_o)
        else $error("maskable interrupt taken while disabled");
    a_fixed_handler: assert property (                             // see RL4
        sel == EV_DIVZ |=> redirect_o && handler_addr_o == HND_DIVZ
            && cause_code_o == CODE_DIVZ)
        else $error("division handler address wrong");
    a_cause_recorded: assert property (                            // see RL5
        sel == EV_ILLEGAL && !flag_pend |=> cause_ff[15:0] == CODE_ILLEGAL
            && ord_save_pc_ff == $past(cur_pc_i))
        else $error("illegal opcode cause not recorded");
    a_trap_ordinary_save: assert property (                        // see RL6
        sel == EV_TRAP && !flag_pend |=> ord_save_pc_ff == $past(next_pc_i)
            && ord_save_st_ff == $past(psw_ff) && flag_pend && flag_id)
        else $error("ordinary trap save wrong");
    a_trap_fatal_half: assert property (                           // see RL7
        sel == EV_TRAP && flag_pend |=> cause_ff[19:16] == $past(trap_vector_i[3:0])
            && cause_ff[31:20] == ($past(trap_vector_i[4]) ? CODE_TRAP1_HI : CODE_TRAP0_HI)
            && flag_nmi_busy && fat_save_pc_ff == $past(next_pc_i))
        else $error("double trap not in fatal half");
    a_trap_vector_group: assert property (                         // see RL8
        sel == EV_TRAP && trap_vector_i[4] |=> handler_addr_o == HND_TRAP1
            && cause_code_o[15:4] == CODE_TRAP1_HI)
        else $error("trap group one vector wrong");
    a_int_area_high: assert property (                             // see RL9
        sel == EV_INT && hwc_ff[HWC_AREA_BIT]
            |=> handler_addr_o == {HND_INT_HIGH_HI, $past(int_level_i), 4'h0})
        else $error("high area interrupt handler wrong");
    a_nmi_vector: assert property (                                // see RL10
        sel == EV_NMI |=> handler_addr_o == HND_NMI && cause_code_o == CODE_NMI
            && fat_save_pc_ff == $past(next_pc_i))
        else $error("nmi entry wrong");

    c_double_trap: cover property (sel == EV_TRAP && flag_pend);
    c_int_high_area: cover property (sel == EV_INT && hwc_ff[HWC_AREA_BIT]);
    c_fatal_over_nmi: cover property (fatal_req_i && nmi_req_i && !reset_pend_ff);
    c_irq_raised: cover property (irq_o);

endmodule

/* File: verif/exception_trap_vectoring_tb_top.sv */
`timescale 1ns/1ps
module exception_trap_vectoring_tb_top;
    import exc_vector_pkg::*;

    // ****************************************
    // Request masks: fatal, nmi, int, trap, illegal, divide
    // ****************************************
    localparam logic [5:0] RQ_FATAL = 6'h20;
    localparam logic [5:0] RQ_NMI   = 6'h10;
    localparam logic [5:0] RQ_INT   = 6'h08;
    localparam logic [5:0] RQ_TRAP  = 6'h04;
    localparam logic [5:0] RQ_ILL   = 6'h02;
    localparam logic [5:0] RQ_DIVZ  = 6'h01;

    logic        clk;
    logic        nrst;
    logic        fatal_req;
    logic [15:0] fatal_code;
    logic        nmi_req;
    logic        int_req;
    logic [3:0]  int_level;
    logic        trap_req;
    logic [4:0]  trap_vector;
    logic        illegal_op;
    logic        div_zero;
    logic [31:0] cur_pc;
    logic [31:0] next_pc;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        we;
    logic        re;
    logic [31:0] rdata;
    logic        redirect;
    logic [31:0] handler_addr;
    logic [15:0] cause_code;
    logic        irq;
    int          miscompares;
    int          checked;
    logic [31:0] exp_h;

    exception_trap_vectoring u_exception_trap_vectoring (
        .clk_i(clk), .nrst_i(nrst), .fatal_req_i(fatal_req), .fatal_code_i(fatal_code),
        .nmi_req_i(nmi_req), .int_req_i(int_req), .int_level_i(int_level),
        .trap_req_i(trap_req), .trap_vector_i(trap_vector), .illegal_op_i(illegal_op),
        .div_zero_i(div_zero), .cur_pc_i(cur_pc), .next_pc_i(next_pc), .addr_i(addr),
        .wdata_i(wdata), .we_i(we), .re_i(re), .rdata_o(rdata), .redirect_o(redirect),
        .handler_addr_o(handler_addr), .cause_code_o(cause_code), .irq_o(irq)
    );

    // Clock, 25 ns period
    initial clk = 1'b0;
    always #12.5 clk = ~clk;

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        we    <= 1'b1;
        @(posedge clk);
        we    <= 1'b0;
    endtask

    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        re   <= 1'b1;
        @(posedge clk);
        re   <= 1'b0;
        #1;
        chk(name, rdata, exp);
    endtask

    // One-cycle request pulse, answer expected exactly one cycle later
    task automatic fire(input logic [5:0] req, input logic take, input logic [31:0] hnd,
                        input logic [15:0] code);
        @(posedge clk);
        {fatal_req, nmi_req, int_req, trap_req, illegal_op, div_zero} <= req;
        @(posedge clk);
        {fatal_req, nmi_req, int_req, trap_req, illegal_op, div_zero} <= 6'h00;
        #1;
        chk("redirect", redirect, take);
        if (take) begin
            chk("handler", handler_addr, hnd);
            if (code !== 16'h0000) chk("cause", cause_code, code);
        end
        @(posedge clk);
        #1;
        chk("redirect_end", redirect, 1'b0);
    endtask

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Watchdog, far beyond the roughly 700 cycles the tests need
    initial begin
        #(20000 * 25);
        miscompares++;
        complete_run();
    end

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        miscompares = 0;
        checked = 0;
        nrst = 1'b0;
        {fatal_req, nmi_req, int_req, trap_req, illegal_op, div_zero} = 6'h00;
        fatal_code = CODE_ILLEGAL;
        int_level = 4'h0;
        trap_vector = 5'h00;
        cur_pc = 32'h0000_2000;
        next_pc = 32'h0000_2004;
        addr = 8'h00;
        wdata = 32'h0;
        we = 1'b0;
        re = 1'b0;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        // Reset entry within a bounded wait
        repeat (4) begin
            @(posedge clk);
            #1;
            if (redirect === 1'b1) break;
        end
        chk("reset_redirect", redirect, 1'b1);
        chk("reset_handler", handler_addr, HND_RESET);
        chk("reset_cause", cause_code, CODE_RESET);
        rd_chk("cause_reg", OFS_CAUSE, CAUSE_RESET);
        rd_chk("psw", OFS_PSW, PSW_RESET);
        rd_chk("status", OFS_EVT_STATUS, 32'h1 << EVB_RESET);
        fire(RQ_INT, 1'b0, 32'h0, 16'h0);
        // Every level in both handler areas
        for (int ar = 0; ar < 2; ar++) begin
            wr(OFS_HW_CONFIG, 32'(ar));
            for (int n = 0; n < 16; n++) begin
                wr(OFS_PSW, 32'h0);
                int_level <= 4'(n);
                exp_h = {(ar == 1) ? HND_INT_HIGH_HI : HND_INT_LOW_HI, 4'(n), 4'h0};
                fire(RQ_INT, 1'b1, exp_h, {CODE_INT_HI, 4'(n), 4'h0});
                rd_chk("ord_pc", OFS_ORD_SAVE_PC, next_pc);
            end
        end
        rd_chk("hw_config", OFS_HW_CONFIG, 32'h1);
        wr(OFS_HW_CONFIG, 32'h0);
        // Interrupt outranks an exception
        wr(OFS_PSW, 32'h0);
        int_level <= 4'h3;
        fire(RQ_INT | RQ_ILL, 1'b1, {HND_INT_LOW_HI, 8'h30}, 16'hFE30);
        // Fatal outranks every interrupt
        wr(OFS_PSW, 32'h0);
        fire(RQ_FATAL | RQ_NMI | RQ_INT, 1'b1, HND_FATAL, fatal_code);
        rd_chk("fat_pc", OFS_FAT_SAVE_PC, cur_pc);
        rd_chk("cause_fat", OFS_CAUSE, {CODE_ILLEGAL, 16'hFE30});
        rd_chk("psw_fat", OFS_PSW, 32'hA0);
        // Nonmaskable taken, then refused while the NMI busy flag is set
        wr(OFS_PSW, 32'h0);
        fire(RQ_NMI, 1'b1, HND_NMI, CODE_NMI);
        rd_chk("nmi_pc", OFS_FAT_SAVE_PC, next_pc);
        wr(OFS_PSW, 32'h80);
        fire(RQ_NMI, 1'b0, 32'h0, 16'h0);
        // Invalid opcode and divide by zero return to current PC
        for (int k = 0; k < 2; k++) begin
            wr(OFS_PSW, 32'h0);
            fire((k == 0) ? RQ_ILL : RQ_DIVZ, 1'b1, (k == 0) ? HND_ILLEGAL : HND_DIVZ,
                 (k == 0) ? CODE_ILLEGAL : CODE_DIVZ);
            rd_chk("exc_pc", OFS_ORD_SAVE_PC, cur_pc);
            rd_chk("psw_exc", OFS_PSW, 32'h60);
        end
        // All trap vectors with the pending flag clear
        for (int v = 0; v < 32; v++) begin
            wr(OFS_PSW, 32'h0);
            trap_vector <= 5'(v);
            next_pc <= 32'h0000_1000 + 32'(v * 4);
            exp_h = (v > 15) ? HND_TRAP1 : HND_TRAP0;
            fire(RQ_TRAP, 1'b1, exp_h,
                 {(v > 15) ? CODE_TRAP1_HI : CODE_TRAP0_HI, 4'(v)});
            rd_chk("trap_pc", OFS_ORD_SAVE_PC, 32'h0000_1000 + 32'(v * 4));
            rd_chk("trap_st", OFS_ORD_SAVE_ST, 32'h0);
            rd_chk("psw_trap", OFS_PSW, 32'h60);
        end
        // Trap with the pending flag set uses the fatal pair and half
        wr(OFS_PSW, 32'h40);
        trap_vector <= 5'h05;
        fire(RQ_TRAP, 1'b1, HND_TRAP0, 16'hFFA5);
        rd_chk("ftrap_pc", OFS_FAT_SAVE_PC, next_pc);
        rd_chk("ftrap_st", OFS_FAT_SAVE_ST, 32'h40);
        rd_chk("psw_ftrap", OFS_PSW, 32'hE0);
        rd_chk("cause_ftrap", OFS_CAUSE, 32'hFFA5_FFBF);
        wr(OFS_CAUSE, 32'h1234_5678);
        rd_chk("cause_ro", OFS_CAUSE, 32'hFFA5_FFBF);
        // Sticky status, mask and level interrupt
        wr(OFS_EVT_STATUS, 32'h7F);
        rd_chk("status_clr", OFS_EVT_STATUS, 32'h0);
        wr(OFS_EVT_MASK, 32'h1 << EVB_TRAP);
        #1;
        chk("irq_idle", irq, 1'b0);
        wr(OFS_PSW, 32'h0);
        fire(RQ_TRAP, 1'b1, HND_TRAP0, 16'hFFA5);
        chk("irq_set", irq, 1'b1);
        wr(OFS_EVT_MASK, 32'h0);
        #1;
        chk("irq_masked", irq, 1'b0);
        wr(OFS_EVT_MASK, 32'h1 << EVB_TRAP);
        #1;
        chk("irq_unmask", irq, 1'b1);
        wr(OFS_EVT_STATUS, 32'h1 << EVB_TRAP);
        #1;
        chk("irq_clear", irq, 1'b0);
        rd_chk("mask", OFS_EVT_MASK, 32'h10);
        rd_chk("unmapped", 8'h30, 32'h0);
        complete_run();
    end

endmodule
